/* File: testbench/dual_byte_port_io_logic_bench.sv */
// Self-checking bench for the two-byte port pin logic.
`timescale 1ns/1ps
`include "port_io_params.svh"
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin \
	error_cnt++; $display("[FAIL] %0t %s", $time, msg); end end
module dual_byte_port_io_logic_bench;
	localparam logic [17:0] A_DIR = {`PORT_A_DIR_IDX, 2'b00};
	localparam logic [17:0] A_LAT = {`PORT_A_LATCH_IDX, 2'b00};
	localparam logic [17:0] A_PU = {`PORT_A_PULLUP_IDX, 2'b00};
	localparam logic [17:0] B_DIR = {`PORT_B_DIR_IDX, 2'b00};
	localparam logic [17:0] B_LAT = {`PORT_B_LATCH_IDX, 2'b00};
	typedef struct {logic [31:0] d; logic e;} note_t;
	note_t notes[$];
	int error_cnt = 0;
	int num_checks = 0;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, bus_data_oe = 0, sw_standby = 0;
	logic hw_standby_n = 1;
	logic [2:0] mode_pins = 3'h7;
	logic [7:0] addr_hi = '0, bus_data_out = '0, bus_data_in;
	logic [7:0] port_a_in, port_a_out, port_a_oe, port_a_pullup;
	logic [7:0] port_b_in, port_b_out, port_b_oe;
	logic [7:0] ext_en = 8'hff, ext_a = 8'h00, ext_b = 8'h00;
	logic [7:0] la, lb, da, db, pe, hi, bo, exp_pu;
	int seed_val;
	logic [31:0] rnd;

	always #4 pclk = ~pclk;

	dual_byte_port_io_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_pins(mode_pins), .hw_standby_n(hw_standby_n),
		.sw_standby(sw_standby), .addr_hi(addr_hi),
		.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
		.bus_data_in(bus_data_in), .port_a_in(port_a_in),
		.port_a_out(port_a_out), .port_a_oe(port_a_oe),
		.port_a_pullup(port_a_pullup), .port_b_in(port_b_in),
		.port_b_out(port_b_out), .port_b_oe(port_b_oe));

	pin_world world (.pclk(pclk), .out_a(port_a_out), .oe_a(port_a_oe),
		.pull_a(port_a_pullup), .out_b(port_b_out), .oe_b(port_b_oe),
		.ext_en(ext_en), .ext_a(ext_a), .ext_b(ext_b), .lvl_a(port_a_in),
		.lvl_b(port_b_in));

	// ----------------------------------------------------------------
	// APB master and read monitor
	// ----------------------------------------------------------------
	task automatic apb(input logic [17:0] a, input logic w,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 100);
		if (n >= 100) `CHK(1'b0, 1'b1, "no pready")
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [17:0] a, input logic [7:0] e,
		input logic err = 1'b0);
		notes.push_back('{{24'h0, e}, err});
		apb(a, 1'b0, 8'h00);
	endtask : rd

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && notes.size() > 0) begin
			`CHK(prdata, notes[0].d, "read data")
			`CHK(pslverr, notes[0].e, "error flag")
			void'(notes.pop_front());
		end
	end

	task automatic set_mode(input logic [2:0] m);
		mode_pins <= m;
		repeat (8) @(posedge pclk);
	endtask : set_mode

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#(8 * 20000);
		error_cnt++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		seed_val = $urandom(32'hb205);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rnd = $urandom;
		ext_a <= rnd[7:0];
		ext_b <= rnd[15:8];
		set_mode(3'h7);
		rd(A_PU, 8'h00);
		rd(B_DIR, 8'hff);
		rd(A_LAT, ext_a);
		rd(B_LAT, ext_b);
		apb(A_DIR, 1'b1, 8'hff);
		apb(B_DIR, 1'b1, 8'hff);
		rd(A_LAT, 8'h00);
		rd(B_LAT, 8'h00);
		rd(18'h00000, 8'h00, 1'b1);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			{la, lb, da, db} = $urandom;
			apb(A_LAT, 1'b1, la);
			apb(B_LAT, 1'b1, lb);
			apb(A_DIR, 1'b1, da);
			apb(B_DIR, 1'b1, db);
			repeat (6) @(posedge pclk);
			rd(A_LAT, (la & da) | (ext_a & ~da));
			rd(B_LAT, (lb & db) | (ext_b & ~db));
			`CHK(port_b_oe, db, "b oe")
			`CHK(port_b_out & db, lb & db, "b out")
			`CHK(port_a_oe, da, "a oe")
			`CHK(port_a_out & da, la & da, "a out")
		end
		$display("test single chip done");
		// Mode 0 is included so the no-function decode is exercised too.
		for (int m = 0; m < 8; m++) begin
			set_mode(m[2:0]);
			{pe, da, hi, bo} = $urandom;
			addr_hi <= hi;
			bus_data_out <= bo;
			bus_data_oe <= 1'b1;
			apb(A_PU, 1'b1, pe);
			apb(A_DIR, 1'b1, da);
			apb(B_DIR, 1'b1, 8'hff);
			repeat (6) @(posedge pclk);
			exp_pu = (m >= 5) ? (pe & ~da) : 8'h00;
			`CHK(port_a_pullup, exp_pu, "pull-ups")
			if (m > 0 && m < 7) begin
				`CHK(port_b_oe, 8'hff, "bus oe")
				`CHK(port_b_out, bo, "bus out")
				bus_data_oe <= 1'b0;
				repeat (8) @(posedge pclk);
				`CHK(port_b_oe, 8'h00, "bus release")
				`CHK(bus_data_in, ext_b, "bus in")
			end
			if (m == 5 || m == 6) begin
				`CHK(port_a_oe, da, "addr oe")
				`CHK(port_a_out & da, hi & da, "addr out")
			end
		end
		bus_data_oe <= 1'b0;
		$display("test modes done");
		set_mode(3'h7);
		rnd = $urandom;
		{lb, pe} = rnd[15:0];
		apb(B_LAT, 1'b1, lb);
		apb(B_DIR, 1'b1, 8'hff);
		apb(A_DIR, 1'b1, 8'h00);
		apb(A_PU, 1'b1, pe);
		sw_standby <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK(port_b_oe, 8'hff, "standby oe")
		`CHK(port_b_out, lb, "standby out")
		`CHK(port_a_pullup, pe, "standby pull")
		sw_standby <= 1'b0;
		rd(B_LAT, lb);
		rd(A_PU, pe);
		apb(A_DIR, 1'b1, 8'hff);
		rd(A_LAT, la);
		hw_standby_n <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK(port_a_pullup, 8'h00, "hw pull")
		`CHK(port_b_oe, 8'h00, "hw oe")
		hw_standby_n <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(A_PU, 8'h00);
		`CHK(port_b_oe, 8'h00, "dir cleared")
		apb(B_DIR, 1'b1, 8'hff);
		apb(A_DIR, 1'b1, 8'hff);
		rd(B_LAT, 8'h00);
		rd(A_LAT, 8'h00);
		$display("test standby done");
		repeat (4) @(posedge pclk);
		report_and_stop();
	end
endmodule : dual_byte_port_io_logic_bench

/* File: testbench/pin_world.sv */
// Behavioural model of the pins and outside world around both ports.
`timescale 1ns/1ps
module pin_world (
	input wire logic pclk,
	input wire logic [7:0] out_a,
	input wire logic [7:0] oe_a,
	input wire logic [7:0] pull_a,
	input wire logic [7:0] out_b,
	input wire logic [7:0] oe_b,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_a,
	input wire logic [7:0] ext_b,
	output logic [7:0] lvl_a,
	output logic [7:0] lvl_b
);
	logic [7:0] float_reg = 8'h5a;

	// A pin nobody drives must not look stable, so it flips every cycle.
	always @(posedge pclk) begin
		float_reg <= ~float_reg;
	end

	// A pulled-up pin with no driver reads high; port B has no pull-ups.
	assign lvl_a = (oe_a & out_a) | (~oe_a & ext_en & ext_a)
		| (~oe_a & ~ext_en & (pull_a | float_reg));
	assign lvl_b = (oe_b & out_b) | (~oe_b & ext_en & ext_b)
		| (~oe_b & ~ext_en & float_reg);
endmodule : pin_world

/* File: verilog/dual_byte_port_io_logic.sv */
// Pin control and APB registers for two general-purpose byte ports.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "port_io_params.svh"
module dual_byte_port_io_logic (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby_n,
	input wire logic sw_standby,
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe,
	output logic [7:0] bus_data_in,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	output logic [7:0] port_a_pullup,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [2:0] mode_sync;
	logic hw_n_sync;
	logic hw_stby;
	port_io_pkg::op_mode_t mode;
	logic exp_rom_off;
	logic rom_exp;
	logic bus_mode;
	logic single;
	logic pu_mode;
	logic [7:0] a_pin_sync;
	logic [7:0] b_pin_sync;
	logic [7:0] a_latch_reg;
	logic [7:0] a_dir_reg;
	logic [7:0] a_pue_reg;
	logic [7:0] b_latch_reg;
	logic [7:0] b_dir_reg;
	logic [7:0] a_dir_eff;
	logic [7:0] a_alt_sel;
	logic [7:0] pullup_next;
	logic setup;
	logic wr_en;
	logic hit_a_dir;
	logic hit_a_latch;
	logic hit_a_pue;
	logic hit_b_dir;
	logic hit_b_latch;
	logic hit_any;
	logic [31:0] rdata_next;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	pin_sync #(
		.WIDTH(4)
	) u_ctl_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level({hw_standby_n, mode_pins}),
		.level_sync({hw_n_sync, mode_sync})
	);

	pin_sync #(
		.WIDTH(16)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_level({port_b_in, port_a_in}),
		.level_sync({b_pin_sync, a_pin_sync})
	);

	// Reset leaves the synchronised standby pin low, so the registers
	// stay cleared until the pin has been seen high twice in a row.
	assign hw_stby = ~hw_n_sync;
	assign bus_data_in = b_pin_sync;

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	assign mode = port_io_pkg::op_mode_t'(mode_sync);
	assign exp_rom_off = (mode >= port_io_pkg::MODE_1) &&
		(mode <= port_io_pkg::MODE_4);
	assign rom_exp = (mode == port_io_pkg::MODE_5) ||
		(mode == port_io_pkg::MODE_6);
	assign bus_mode = exp_rom_off | rom_exp;
	assign single = (mode == port_io_pkg::MODE_7);
	assign pu_mode = rom_exp | single;

	// Port A direction counts as fixed ones for latch reads in modes 1 to 4, where every pin carries the address.
	assign a_dir_eff = exp_rom_off ? `PORT_DIR_FIXED : a_dir_reg;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & ~pslverr_reg;
	assign hit_a_dir = (paddr == {`PORT_A_DIR_IDX, 2'b00});
	assign hit_a_latch = (paddr == {`PORT_A_LATCH_IDX, 2'b00});
	assign hit_a_pue = (paddr == {`PORT_A_PULLUP_IDX, 2'b00});
	assign hit_b_dir = (paddr == {`PORT_B_DIR_IDX, 2'b00});
	assign hit_b_latch = (paddr == {`PORT_B_LATCH_IDX, 2'b00});
	assign hit_any = hit_a_dir | hit_a_latch | hit_a_pue | hit_b_dir |
		hit_b_latch;
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit_a_latch) begin
			rdata_next[7:0] = (a_latch_reg & a_dir_eff) |
				(a_pin_sync & ~a_dir_eff);
		end
		if (hit_a_pue) begin
			rdata_next[7:0] = a_pue_reg;
		end
		if (hit_a_dir | hit_b_dir) begin
			rdata_next[7:0] = `PORT_DIR_READ;
		end
		if (hit_b_latch) begin
			rdata_next[7:0] = (b_latch_reg & b_dir_reg) |
				(b_pin_sync & ~b_dir_reg);
		end
	end

	// Read data and the error flag are captured in the setup cycle so
	// both come from flops and stand through the zero-wait access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
			pslverr_reg <= ~hit_any;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// port A latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_latch_reg <= `PORT_REG_RST;
		end else if (hw_stby) begin
			a_latch_reg <= `PORT_REG_RST;
		end else if (wr_en && hit_a_latch) begin
			a_latch_reg <= pwdata[7:0];
		end
	end

	// Writes in modes 1 to 4 are dropped; the effective value is fixed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_dir_reg <= `PORT_REG_RST;
		end else if (hw_stby) begin
			a_dir_reg <= `PORT_REG_RST;
		end else if (wr_en && hit_a_dir && !exp_rom_off) begin
			a_dir_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_pue_reg <= `PORT_REG_RST;
		end else if (hw_stby) begin
			a_pue_reg <= `PORT_REG_RST;
		end else if (wr_en && hit_a_pue) begin
			a_pue_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_dir_reg <= `PORT_REG_RST;
		end else if (hw_stby) begin
			b_dir_reg <= `PORT_REG_RST;
		end else if (wr_en && hit_b_dir) begin
			b_dir_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_latch_reg <= `PORT_REG_RST;
		end else if (hw_stby) begin
			b_latch_reg <= `PORT_REG_RST;
		end else if (wr_en && hit_b_latch) begin
			b_latch_reg <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Pull-ups
	// ------------------------------------------------------------------
	// pull-up gating
	assign pullup_next = (pu_mode && !hw_stby) ?
		(a_pue_reg & ~a_dir_reg) : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a_pullup <= 8'h00;
		end else begin
			port_a_pullup <= pullup_next;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	// port A pin function
	assign a_alt_sel = exp_rom_off ? 8'hff : (rom_exp ? a_dir_reg : 8'h00);

	pin_drive #(
		.WIDTH(8)
	) u_drive_a (
		.pclk(pclk),
		.presetn(presetn),
		.drive_off(hw_stby),
		.gpio_en(single),
		.alt_sel(a_alt_sel),
		.alt_val(addr_hi),
		.alt_oe(8'hff),
		.dir(a_dir_reg),
		.latch(a_latch_reg),
		.pin_out(port_a_out),
		.pin_oe(port_a_oe)
	);

	// port B function
	// Software standby does not gate the driver, so output pins hold.
	pin_drive #(
		.WIDTH(8)
	) u_drive_b (
		.pclk(pclk),
		.presetn(presetn),
		.drive_off(hw_stby),
		.gpio_en(single),
		.alt_sel({8{bus_mode}}),
		.alt_val(bus_data_out),
		.alt_oe({8{bus_data_oe}}),
		.dir(b_dir_reg),
		.latch(b_latch_reg),
		.pin_out(port_b_out),
		.pin_oe(port_b_oe)
	);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_a_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_a_latch && !hw_stby) |=>
			(a_latch_reg == $past(pwdata[7:0]));
	endproperty
	a_a_wr: assert property (p_a_wr)
		else $error("port A latch missed a write");

	property p_a_rd;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_a_latch && a_dir_eff == 8'hff) ##1
			(penable && !hw_stby) |-> (prdata[7:0] == a_latch_reg);
	endproperty
	a_a_rd: assert property (p_a_rd)
		else $error("port A read did not return the latch");

	property p_a_clr;
		@(posedge pclk) disable iff (!presetn)
		hw_stby |=> (a_latch_reg == 8'h00);
	endproperty
	a_a_clr: assert property (p_a_clr)
		else $error("port A latch not cleared in standby");

	property p_pu_on;
		@(posedge pclk) disable iff (!presetn)
		(pu_mode && !hw_stby) |=>
			(port_a_pullup == $past(a_pue_reg & ~a_dir_reg));
	endproperty
	a_pu_on: assert property (p_pu_on)
		else $error("pull-up does not follow enable and input");

	property p_pu_off_mode;
		@(posedge pclk) disable iff (!presetn)
		exp_rom_off |=> (port_a_pullup == 8'h00);
	endproperty
	a_pu_off_mode: assert property (p_pu_off_mode)
		else $error("pull-up on in an address-bus mode");

	property p_pu_off_stby;
		@(posedge pclk) disable iff (!presetn)
		hw_stby |=> (port_a_pullup == 8'h00);
	endproperty
	a_pu_off_stby: assert property (p_pu_off_stby)
		else $error("pull-up on in hardware standby");

	property p_pue_clr;
		@(posedge pclk) disable iff (!presetn)
		hw_stby |=> (a_pue_reg == 8'h00);
	endproperty
	a_pue_clr: assert property (p_pue_clr)
		else $error("pull-up enable not cleared in standby");

	property p_b_bus;
		@(posedge pclk) disable iff (!presetn)
		(bus_mode && !hw_stby) |=> (port_b_out == $past(bus_data_out)) &&
			(port_b_oe == {8{$past(bus_data_oe)}});
	endproperty
	a_b_bus: assert property (p_b_bus)
		else $error("port B does not carry the data bus");

	property p_b_dir_ign;
		@(posedge pclk) disable iff (!presetn)
		(bus_mode && !hw_stby && !bus_data_oe) |=> (port_b_oe == 8'h00);
	endproperty
	a_b_dir_ign: assert property (p_b_dir_ign)
		else $error("port B direction acted in a bus mode");

	property p_b_gpio;
		@(posedge pclk) disable iff (!presetn)
		(single && !hw_stby) |=> (port_b_oe == $past(b_dir_reg)) &&
			(port_b_out == $past(b_latch_reg));
	endproperty
	a_b_gpio: assert property (p_b_gpio)
		else $error("port B pins do not follow direction");

	property p_b_dir_rd;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_b_dir) |=> (prdata == 32'h0000_00ff);
	endproperty
	a_b_dir_rd: assert property (p_b_dir_rd)
		else $error("port B direction read not all ones");

	property p_b_dir_clr;
		@(posedge pclk) disable iff (!presetn)
		hw_stby |=> (b_dir_reg == 8'h00);
	endproperty
	a_b_dir_clr: assert property (p_b_dir_clr)
		else $error("port B direction not cleared in standby");

	property p_b_hold;
		@(posedge pclk) disable iff (!presetn)
		(single && sw_standby && !hw_stby) ##1 (sw_standby && !hw_stby) |=>
			(port_b_oe == $past(port_b_oe, 1));
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("port B output dropped in software standby");

	property p_b_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_b_latch && !hw_stby) |=>
			(b_latch_reg == $past(pwdata[7:0]));
	endproperty
	a_b_wr: assert property (p_b_wr)
		else $error("port B latch missed a write");

	property p_b_rd;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_b_latch && b_dir_reg == 8'h00) |=>
			(prdata[7:0] == $past(b_pin_sync));
	endproperty
	a_b_rd: assert property (p_b_rd)
		else $error("port B read did not return pin levels");

	property p_b_clr;
		@(posedge pclk) disable iff (!presetn)
		hw_stby |=> (b_latch_reg == 8'h00);
	endproperty
	a_b_clr: assert property (p_b_clr)
		else $error("port B latch not cleared in standby");

	property p_a_addr;
		@(posedge pclk) disable iff (!presetn)
		(rom_exp && !hw_stby) |=> (port_a_oe == $past(a_dir_reg)) &&
			(((port_a_out ^ $past(addr_hi)) & $past(a_dir_reg)) == 8'h00);
	endproperty
	a_a_addr: assert property (p_a_addr)
		else $error("port A does not output the address");

	property p_a_gpio;
		@(posedge pclk) disable iff (!presetn)
		(single && !hw_stby) |=> (port_a_oe == $past(a_dir_reg)) &&
			(port_a_out == $past(a_latch_reg));
	endproperty
	a_a_gpio: assert property (p_a_gpio)
		else $error("port A pins do not follow direction");

endmodule : dual_byte_port_io_logic

/* File: verilog/pin_drive.sv */
// Registered pin driver choosing between an alternate function and GPIO.
`timescale 1ns/1ps
module pin_drive #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic drive_off,
	input wire logic gpio_en,
	input wire logic [WIDTH-1:0] alt_sel,
	input wire logic [WIDTH-1:0] alt_val,
	input wire logic [WIDTH-1:0] alt_oe,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] latch,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe
);

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_drive needs at least one bit");
	end

	// Every pin is released while the driver is off, so a hardware
	// standby never leaves a pin fighting the board.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_out[i] <= 1'b0;
				pin_oe[i] <= 1'b0;
			end else if (drive_off) begin
				pin_out[i] <= 1'b0;
				pin_oe[i] <= 1'b0;
			end else if (alt_sel[i]) begin
				pin_out[i] <= alt_val[i];
				pin_oe[i] <= alt_oe[i];
			end else begin
				pin_out[i] <= latch[i];
				pin_oe[i] <= gpio_en & dir[i];
			end
		end
	end

endmodule : pin_drive

/* File: verilog/pin_sync.sv */
// Three-flop pin synchroniser with an agreement filter.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_level,
	output logic [WIDTH-1:0] level_sync
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync needs at least one bit");
	end

	// synchronise pin levels
	// The first stage feeds only the second; a bit counts once stages two
	// and three agree, which keeps a late-settling stage from leaking out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			level_sync <= '0;
		end else begin
			stage1_reg <= pin_level;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_sync[i] <= stage3_reg[i];
				end
			end
		end
	end

endmodule : pin_sync

/* File: verilog/port_io_params.svh */
// Offsets, reset values and fixed read values of the two-byte port pin logic.
// How it works
// - Port A output latch is 8 bits, read/write, one bit per pin.
// - Port A read returns latch where direction is 1, pin level where 0.
// - Port A latch clears on reset and hardware standby; kept in software standby.
// - Modes 5 to 7: pull-up on when direction bit 0 and enable bit 1.
// - Modes 1 to 4: port A pull-ups always off.
// - Pull-ups off during reset and hardware standby in every mode.
// - Port A pull-up enable clears on reset and hardware standby only.
// - Modes 1 to 6: port B pins carry upper data bus bits 15 to 8.
// - Modes 1 to 6: port B direction register has no effect.
// - Mode 7: port B pin drives latch when direction 1, else input.
// - Port B direction is write-only and reads as all ones.
// - Port B direction clears on reset and hardware standby only.
// - Software standby: port B output pins keep driving.
// - Port B output latch is 8 bits, read/write, one bit per pin.
// - Port B read returns latch where direction is 1, pin level where 0.
// - Port B latch clears on reset and hardware standby only.
// - Modes 5 and 6: port A direction 1 outputs address 15 to 8, else input.
// - Mode 7: port A pin drives latch when direction 1, else input.
`ifndef PORT_IO_PARAMS_SVH
`define PORT_IO_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices; the APB byte address is four times the index.
// ----------------------------------------------------------------------
`define PORT_A_DIR_IDX 16'hffc1
`define PORT_A_LATCH_IDX 16'hffc3
`define PORT_A_PULLUP_IDX 16'hffd8
`define PORT_B_DIR_IDX 16'hffc4
`define PORT_B_LATCH_IDX 16'hffc6

// ----------------------------------------------------------------------
// Reset and fixed read values.
// ----------------------------------------------------------------------
`define PORT_REG_RST 8'h00
`define PORT_DIR_READ 8'hff
`define PORT_DIR_FIXED 8'hff

`endif

/* File: verilog/port_io_pkg.sv */
// Types shared by the two-byte port pin logic.
package port_io_pkg;

	typedef enum logic [2:0] {
		MODE_NONE = 3'b000,
		MODE_1 = 3'b001,
		MODE_2 = 3'b010,
		MODE_3 = 3'b011,
		MODE_4 = 3'b100,
		MODE_5 = 3'b101,
		MODE_6 = 3'b110,
		MODE_7 = 3'b111
	} op_mode_t;

endpackage : port_io_pkg
